// ==== include/nfcs_defines.vh ====
// Command codes, address counts and strobe timing for the NAND flash sequencer
`ifndef NFCS_DEFINES_VH
`define NFCS_DEFINES_VH
`define NFCS_CMD_READ 8'h00
`define NFCS_CMD_PROG 8'h80
`define NFCS_CMD_PROG_GO 8'h10
`define NFCS_CMD_ERASE 8'h60
`define NFCS_CMD_ERASE_GO 8'hD0
`define NFCS_CMD_STATUS 8'h70
`define NFCS_OP_READ 2'h0
`define NFCS_OP_PROG 2'h1
`define NFCS_OP_ERASE 2'h2
`define NFCS_OP_STATUS 2'h3
`define NFCS_ROW_BYTES 3'h3
`define NFCS_PAGE_BITS 5
`define NFCS_CLK_MHZ 20
`define NFCS_STROBE_NS 50
`define NFCS_STROBE_CYC ((`NFCS_STROBE_NS * `NFCS_CLK_MHZ + 999) / 1000)
`endif

// ==== logic/nfcs_strobe.v ====
// Strobe pulse generator: one low pulse per request, with hold and recovery
`timescale 1ns/1ps
`include "nfcs_defines.vh"
module nfcs_strobe #(
	parameter CYC = `NFCS_STROBE_CYC
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire reset_n_i,
	// Request
	input wire go_i,
	// Status
	output reg strobe_n_o,
	output reg done_o,
	output wire busy_o
);
	reg [3:0] cnt_r;
	reg [1:0] ph_r;
	assign busy_o = (ph_r != 2'h0);
	// Low phase then equal high recovery, so back-to-back pulses stay legal
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r <= 4'h0;
			ph_r <= 2'h0;
			strobe_n_o <= 1'b1;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (ph_r)
			2'h0: begin
				if (go_i) begin
					strobe_n_o <= 1'b0;
					ph_r <= 2'h1;
					cnt_r <= CYC[3:0];
				end
			end
			2'h1: begin
				if (cnt_r <= 4'h1) begin
					strobe_n_o <= 1'b1;
					ph_r <= 2'h2;
					cnt_r <= CYC[3:0];
				end else begin
					cnt_r <= cnt_r - 4'h1;
				end
			end
			2'h2: begin
				if (cnt_r <= 4'h1) begin
					ph_r <= 2'h0;
					done_o <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 4'h1;
				end
			end
			default: ph_r <= 2'h0;
			endcase
		end
	end
endmodule

// ==== logic/nfcs_host.v ====
// Host-side NAND flash command sequencer: read, program, erase, status
// Functional notes
// (RULE_01) Address bytes latched per write strobe rising
// (RULE_02) Column byte first, then row bytes
// (RULE_03) Row byte: low five page, upper block
// (RULE_04) Flash busy low during page fetch
// (RULE_05) When ready, one byte per read strobe
// (RULE_06) Program starts with command 0x80
// (RULE_07) Program address like read address
// (RULE_08) Data bytes written, latches low, per strobe
// (RULE_09) Confirm program, flash busy until done
// (RULE_10) Read status after program ends
// (RULE_11) Erase starts with command 0x60
// (RULE_12) Erase sends only block address bytes
// (RULE_13) Confirm erase with 0xD0, then busy
// (RULE_14) Read status after erase ends
// (RULE_15) Erase clears a block of pages
// (RULE_16) Program clears bits; erase sets them
// (RULE_17) Keep chip select low while busy
// (RULE_18) Select and latches driven as flag outputs
// (RULE_19) Ready rising edge signals operation done
// (RULE_20) 32-bit words split into four bytes
// (RULE_21) Single command gives exactly one strobe
// (RULE_22) Page read starts with command 0x00
// (RULE_23) Latch levels select data, command, address
// (RULE_24) Chip select high makes flash ignore strobes
// (RULE_25) No new command while flash busy
`timescale 1ns/1ps
`include "nfcs_defines.vh"
module nfcs_host #(
	parameter WORDS = 132
) (
	// Clock and reset
	input wire sys_clk_i,
	input wire reset_n_i,
	// Operation request
	input wire start_i,
	input wire [1:0] op_i,
	input wire [7:0] column_i,
	input wire [23:0] row_i,
	output reg busy_o,
	output reg done_o,
	output reg [7:0] status_o,
	// Write word stream
	input wire [31:0] wr_word_i,
	input wire wr_valid_i,
	output reg wr_ready_o,
	// Read word stream
	output reg [31:0] rd_word_o,
	output reg rd_valid_o,
	// Flash pins
	output reg gp_out_zero_n_o,
	output reg gp_out_one_o,
	output reg addr_latch_o,
	output reg wr_n_o,
	output reg rd_n_o,
	output reg [7:0] io_o,
	output reg io_oe_o,
	input wire [7:0] io_i,
	input wire routed_input_pin_i
);
	localparam S_IDLE = 4'h0;
	localparam S_CMD1 = 4'h1;
	localparam S_ADDR = 4'h2;
	localparam S_DATA = 4'h3;
	localparam S_CMD2 = 4'h4;
	localparam S_WAIT = 4'h5;
	localparam S_RDAT = 4'h6;
	localparam S_STAT = 4'h7;
	localparam S_SRD = 4'h8;
	localparam S_END = 4'h9;
	reg [3:0] st_r;
	reg [1:0] op_r;
	reg [7:0] col_r;
	reg [23:0] row_r;
	reg [2:0] acnt_r;
	reg [1:0] bcnt_r;
	reg [15:0] wcnt_r;
	reg [31:0] word_r;
	reg rb_s1_r;
	reg rb_s2_r;
	reg rb_s3_r;
	reg go_r;
	reg use_rd_r;
	reg [7:0] rd_cap_r;
	wire sdone;
	wire sbusy;
	wire rb_rise;
	wire stb_n;
	// Ready/busy pin synchronised before any use
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rb_s1_r <= 1'b1;
			rb_s2_r <= 1'b1;
			rb_s3_r <= 1'b1;
		end else begin
			rb_s1_r <= routed_input_pin_i;
			rb_s2_r <= rb_s1_r;
			rb_s3_r <= rb_s2_r;
		end
	end
	assign rb_rise = rb_s2_r & ~rb_s3_r; // RULE_19
	// Bus taken as the read strobe rises; the flash holds it steady under
	// the strobe, so one enabled flop is enough and no synchroniser is needed
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_cap_r <= 8'h00;
		end else if (!rd_n_o) begin
			rd_cap_r <= io_i; // RULE_05
		end
	end
	// One shared timer; the strobe pin it drives is chosen by use_rd_r
	nfcs_strobe #(.CYC(`NFCS_STROBE_CYC)) u_stb (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.go_i(go_r),
		.strobe_n_o(stb_n),
		.done_o(sdone),
		.busy_o(sbusy)
	);
	// Sequencer; each pin comes from a flop, strobes follow the timer
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= S_IDLE;
			op_r <= 2'h0;
			col_r <= 8'h00;
			row_r <= 24'h000000;
			acnt_r <= 3'h0;
			bcnt_r <= 2'h0;
			wcnt_r <= 16'h0000;
			word_r <= 32'h00000000;
			go_r <= 1'b0;
			use_rd_r <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			status_o <= 8'h00;
			wr_ready_o <= 1'b0;
			rd_word_o <= 32'h00000000;
			rd_valid_o <= 1'b0;
			gp_out_zero_n_o <= 1'b1;
			gp_out_one_o <= 1'b0;
			addr_latch_o <= 1'b0;
			wr_n_o <= 1'b1;
			rd_n_o <= 1'b1;
			io_o <= 8'h00;
			io_oe_o <= 1'b0;
		end else begin
			go_r <= 1'b0;
			done_o <= 1'b0;
			rd_valid_o <= 1'b0;
			wr_ready_o <= 1'b0;
			wr_n_o <= use_rd_r | stb_n;
			rd_n_o <= ~use_rd_r | stb_n;
			case (st_r)
			S_IDLE: begin
				gp_out_zero_n_o <= 1'b1; // RULE_24
				io_oe_o <= 1'b0;
				if (start_i && rb_s2_r) begin // RULE_25
					op_r <= op_i;
					col_r <= column_i;
					row_r <= row_i;
					busy_o <= 1'b1;
					gp_out_zero_n_o <= 1'b0; // RULE_18
					gp_out_one_o <= 1'b1; // RULE_23
					addr_latch_o <= 1'b0;
					io_oe_o <= 1'b1;
					use_rd_r <= 1'b0;
					go_r <= 1'b1; // RULE_21
					if (op_i == `NFCS_OP_PROG)
						io_o <= `NFCS_CMD_PROG; // RULE_06
					else if (op_i == `NFCS_OP_ERASE)
						io_o <= `NFCS_CMD_ERASE; // RULE_11
					else if (op_i == `NFCS_OP_STATUS)
						io_o <= `NFCS_CMD_STATUS;
					else
						io_o <= `NFCS_CMD_READ; // RULE_22
					st_r <= (op_i == `NFCS_OP_STATUS) ? S_STAT : S_CMD1;
					acnt_r <= 3'h0;
				end
			end
			S_CMD1: begin
				if (sdone) begin
					gp_out_one_o <= 1'b0;
					addr_latch_o <= 1'b1; // RULE_01
					// Erase skips the column byte, block bytes only
					if (op_r == `NFCS_OP_ERASE) begin // RULE_12
						io_o <= row_r[7:0];
						acnt_r <= 3'h1;
					end else begin
						io_o <= col_r; // RULE_02
						acnt_r <= 3'h0;
					end
					go_r <= 1'b1;
					st_r <= S_ADDR;
				end
			end
			S_ADDR: begin
				if (sdone) begin
					if (acnt_r == `NFCS_ROW_BYTES) begin
						addr_latch_o <= 1'b0;
						wcnt_r <= WORDS[15:0];
						bcnt_r <= 2'h0;
						if (op_r == `NFCS_OP_ERASE) begin
							gp_out_one_o <= 1'b1;
							io_o <= `NFCS_CMD_ERASE_GO; // RULE_13
							go_r <= 1'b1;
							st_r <= S_CMD2;
						end else if (op_r == `NFCS_OP_PROG) begin
							wr_ready_o <= 1'b1; // RULE_07
							st_r <= S_DATA;
						end else begin
							io_oe_o <= 1'b0;
							st_r <= S_WAIT; // RULE_04
						end
					end else begin
						// Row bytes low first; first carries page and block
						io_o <= row_r[8*acnt_r +: 8]; // RULE_03
						acnt_r <= acnt_r + 3'h1;
						go_r <= 1'b1;
					end
				end
			end
			S_DATA: begin
				// A finished last byte must count its word before a new one is taken
				if (bcnt_r == 2'h0 && !sbusy && !go_r && !sdone) begin
					if (wcnt_r == 16'h0000) begin
						gp_out_one_o <= 1'b1;
						io_o <= `NFCS_CMD_PROG_GO; // RULE_09
						go_r <= 1'b1;
						st_r <= S_CMD2;
					end else if (wr_valid_i) begin
						word_r <= wr_word_i;
						io_o <= wr_word_i[7:0]; // RULE_20
						bcnt_r <= 2'h1;
						go_r <= 1'b1; // RULE_08
					end else begin
						wr_ready_o <= 1'b1;
					end
				end else if (sdone) begin
					if (bcnt_r == 2'h0) begin
						wcnt_r <= wcnt_r - 16'h0001;
						wr_ready_o <= (wcnt_r != 16'h0001);
					end else begin
						io_o <= word_r[8*bcnt_r +: 8];
						bcnt_r <= bcnt_r + 2'h1;
						go_r <= 1'b1;
						if (bcnt_r == 2'h3)
							bcnt_r <= 2'h0;
					end
				end
			end
			S_CMD2: begin
				if (sdone) begin
					gp_out_one_o <= 1'b0;
					io_oe_o <= 1'b0;
					st_r <= S_WAIT;
				end
			end
			S_WAIT: begin
				// Select stays low through busy for standard parts
				gp_out_zero_n_o <= 1'b0; // RULE_17
				if (rb_rise) begin // RULE_19
					if (op_r == `NFCS_OP_READ) begin
						use_rd_r <= 1'b1;
						go_r <= 1'b1; // RULE_05
						bcnt_r <= 2'h0;
						st_r <= S_RDAT;
					end else begin
						gp_out_one_o <= 1'b1;
						io_oe_o <= 1'b1;
						io_o <= `NFCS_CMD_STATUS; // RULE_10 RULE_14
						go_r <= 1'b1;
						st_r <= S_STAT;
					end
				end
			end
			S_RDAT: begin
				if (sdone) begin
					word_r[8*bcnt_r +: 8] <= rd_cap_r;
					bcnt_r <= bcnt_r + 2'h1;
					if (bcnt_r == 2'h3) begin
						rd_word_o <= {rd_cap_r, word_r[23:0]}; // RULE_20
						rd_valid_o <= 1'b1;
						wcnt_r <= wcnt_r - 16'h0001;
					end
					if (bcnt_r == 2'h3 && wcnt_r == 16'h0001) begin
						use_rd_r <= 1'b0;
						st_r <= S_END;
					end else begin
						go_r <= 1'b1;
					end
				end
			end
			S_STAT: begin
				if (sdone) begin
					gp_out_one_o <= 1'b0;
					io_oe_o <= 1'b0;
					use_rd_r <= 1'b1;
					go_r <= 1'b1;
					st_r <= S_SRD;
				end
			end
			S_SRD: begin
				if (sdone) begin
					status_o <= rd_cap_r;
					use_rd_r <= 1'b0;
					st_r <= S_END;
				end
			end
			S_END: begin
				gp_out_zero_n_o <= 1'b1;
				busy_o <= 1'b0;
				done_o <= 1'b1;
				st_r <= S_IDLE;
			end
			default: st_r <= S_IDLE;
			endcase
		end
	end
endmodule

// ==== tb/nfcs_flash_model.sv ====
// Behavioural NAND flash seen from its pins
`timescale 1ns/1ps
module nfcs_flash_model #(
	parameter BUSY_NS = 2000,
	parameter [7:0] STAT = 8'hC0
) (
	// Control pins
	input wire cs_n_i,
	input wire cle_i,
	input wire ale_i,
	input wire we_n_i,
	input wire re_n_i,
	// Data and ready
	input wire [7:0] io_i,
	output logic [7:0] io_o,
	output logic rb_o
);
	logic [7:0] mem [0:7];
	logic [7:0] dreg [0:7];
	logic [7:0] cmd, col, row0;
	int na, nd;
	// Array starts programmed so an erase must really set bits
	initial begin
		rb_o = 1'b1;
		io_o = 8'h5A;
		cmd = 8'hFF;
		col = 8'h00;
		row0 = 8'h00;
		na = 0;
		nd = 0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	task go_busy;
		rb_o <= 1'b0;
		rb_o <= #(BUSY_NS) 1'b1;
	endtask
	// Everything latches on the rising write strobe
	always @(posedge we_n_i) begin
		if (!cs_n_i && rb_o) begin
			if (cle_i && !ale_i) begin
				cmd = io_i;
				na = 0;
				nd = 0;
				if (io_i == 8'h80)
					foreach (dreg[i]) dreg[i] = 8'hFF;
				if (io_i == 8'h10)
					foreach (mem[i]) mem[i] &= dreg[i];
				if (io_i == 8'hD0)
					foreach (mem[i]) mem[i] = 8'hFF;
				if (io_i == 8'h10 || io_i == 8'hD0)
					go_busy();
			end else if (ale_i && !cle_i) begin
				if (na == 0 && cmd != 8'h60)
					col = io_i;
				// First row byte holds the page index and low block bits
				if (na == ((cmd == 8'h60) ? 0 : 1))
					row0 = io_i;
				na++;
				if (cmd == 8'h00 && na == 4)
					go_busy();
			end else if (!ale_i && !cle_i) begin
				dreg[col[2:0] + nd[2:0]] = io_i;
				nd++;
			end
		end
	end
	// Byte driven from the falling read strobe
	always @(negedge re_n_i) begin
		if (!cs_n_i && rb_o) begin
			io_o = (cmd == 8'h70) ? STAT : mem[col[2:0] + nd[2:0]];
			nd++;
		end
	end
	// Hold runs out before the next edge, so stale data cannot pass
	always @(posedge re_n_i) io_o <= #40 ~io_o;
endmodule

// ==== tb/nfcs_host_sva.sv ====
// Pin assertions for the flash sequencer
`timescale 1ns/1ps
module nfcs_host_sva (
	// Clock and reset
	input wire sys_clk_i,
	input wire reset_n_i,
	// Watched ports
	input wire busy_o,
	input wire gp_out_zero_n_o,
	input wire gp_out_one_o,
	input wire addr_latch_o,
	input wire wr_n_o,
	input wire rd_n_o,
	input wire io_oe_o,
	input wire routed_input_pin_i
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_LATCH: assert property (!(gp_out_one_o && addr_latch_o))
		else $error("both latches high");
	AST_HOLD: assert property ($fell(wr_n_o) |->
		!gp_out_zero_n_o ##1 $stable({gp_out_one_o, addr_latch_o}))
		else $error("select moved in write strobe");
	AST_WIDTH: assert property ($fell(wr_n_o) |=> $rose(wr_n_o))
		else $error("write strobe width");
	AST_RECOV: assert property ($rose(wr_n_o) |=> wr_n_o)
		else $error("write strobe recovery");
	AST_RD_SEL: assert property ($fell(rd_n_o) |->
		!gp_out_zero_n_o && !gp_out_one_o && !addr_latch_o && !io_oe_o && wr_n_o)
		else $error("read strobe selection");
	AST_RDY: assert property ($fell(wr_n_o & rd_n_o) |-> routed_input_pin_i)
		else $error("strobe while flash busy");
	AST_CS_BUSY: assert property (busy_o && !routed_input_pin_i |-> !gp_out_zero_n_o)
		else $error("select dropped while busy");
	AST_IO_OE: assert property (!wr_n_o |-> io_oe_o)
		else $error("write strobe undriven");
	cover property ($rose(routed_input_pin_i));
	cover property ($fell(rd_n_o));
	cover property ($fell(wr_n_o) && gp_out_one_o);
endmodule
bind nfcs_host nfcs_host_sva u_sva (.sys_clk_i, .reset_n_i, .busy_o, .gp_out_zero_n_o,
	.gp_out_one_o, .addr_latch_o, .wr_n_o, .rd_n_o, .io_oe_o, .routed_input_pin_i);

// ==== tb/test_nfcs_host.sv ====
// Self-checking bench: sequencer against a flash model
`timescale 1ns/1ps
module test_nfcs_host;
	localparam W = 2;
	localparam [31:0] ST = 32'hC0;
	logic sys_clk_i, reset_n_i, start_i, wr_valid_i, busy_o, done_o, wr_ready_o, rd_valid_o;
	logic cs_n, cle, ale, we_n, re_n, io_oe, rb;
	logic [1:0] op_i, last_op;
	logic [7:0] column_i, io_o, io_i, status_o;
	logic [23:0] row_i;
	logic [31:0] wr_word_i, rd_word_o, seed;
	logic [31:0] wd [0:W-1];
	logic [31:0] img [0:W-1];
	logic [31:0] q [$];
	int n_mismatch, n_tests, wi;
	nfcs_host #(.WORDS(W)) DUT (.sys_clk_i, .reset_n_i, .start_i, .op_i, .column_i, .row_i,
		.busy_o, .done_o, .status_o, .wr_word_i, .wr_valid_i, .wr_ready_o, .rd_word_o,
		.rd_valid_o, .gp_out_zero_n_o(cs_n), .gp_out_one_o(cle), .addr_latch_o(ale),
		.wr_n_o(we_n), .rd_n_o(re_n), .io_o, .io_oe_o(io_oe), .io_i, .routed_input_pin_i(rb));
	nfcs_flash_model FLASH (.cs_n_i(cs_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
		.re_n_i(re_n), .io_i(io_oe ? io_o : ~io_o), .io_o(io_i), .rb_o(rb));
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input [31:0] got, input [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// One operation, row from the random stream, waits for completion
	task automatic run(input [1:0] op);
		int i;
		i = 0;
		seed = lfsr(seed);
		op_i <= op;
		last_op <= op;
		row_i <= seed[23:0];
		start_i <= 1'b1;
		@(posedge sys_clk_i);
		start_i <= 1'b0;
		while (done_o !== 1'b1 && i < 20000) begin
			@(posedge sys_clk_i);
			i++;
		end
		if (i >= 20000)
			n_mismatch++;
		if (op != 2'h3)
			check({24'h0, FLASH.row0}, {24'h0, row_i[7:0]});
		@(posedge sys_clk_i);
	endtask
	// Next program word handed over after each accepted one
	always @(posedge sys_clk_i) begin
		if (wr_ready_o === 1'b1 && wr_valid_i) begin
			wi <= wi + 1;
			wr_word_i <= wd[(wi + 1) % W];
		end
	end
	// Results compared in order against the oldest note
	always @(posedge sys_clk_i) begin
		if (rd_valid_o === 1'b1)
			check(rd_word_o, q.pop_front());
		if (done_o === 1'b1 && last_op != 2'h0)
			check({24'h0, status_o}, q.pop_front());
	end
	// Whole run is some 1200 cycles; twenty-five times that means a hang
	initial begin
		repeat (30000) @(posedge sys_clk_i);
		n_mismatch++;
		complete_run();
	end
	initial begin
		{reset_n_i, start_i, wr_valid_i, op_i, last_op, column_i, row_i} = 0;
		{wr_word_i, n_mismatch, n_tests, wi} = 0;
		seed = 32'h53A;
		repeat (8) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		wr_valid_i <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			q.push_back(ST);
			run(2'h2);
			foreach (img[k]) img[k] = 32'hFFFFFFFF;
			foreach (img[k]) q.push_back(img[k]);
			run(2'h0);
			for (int p = 0; p < 2; p++) begin
				foreach (wd[k]) begin
					seed = lfsr(seed);
					wd[k] = seed;
					img[k] &= seed;
				end
				wi <= 0;
				wr_word_i <= wd[0];
				q.push_back(ST);
				run(2'h1);
				foreach (img[k]) q.push_back(img[k]);
				run(2'h0);
			end
			q.push_back(ST);
			run(2'h3);
		end
		complete_run();
	end
endmodule
